//--- hdl/interrupt_stack_status.v
/*
 * Interrupt control, vector generation, a 16-entry operand stack, the return stack pointer and the
 * condition flags of the embedded processor: source gating and priority,
 * sticky status with enable and clear, the register port that software
 * uses to reach all of it, and the bidirectional interrupt pin.
 * Assumes a single clock, a synchronous active-high reset, a register
 * master with one-cycle strobes that never overlap, and core and source
 * signals on this clock except the bidirectional pin, which is
 * synchronised here. The pad itself, with its output enable active low,
 * sits outside this block.
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "irq_stack_consts.vh"

module interrupt_stack_status #(
    parameter DEPTH = `STACK_DEPTH
) (
    // Clock, reset and register port
    input  wire        clk,
    input  wire        rst,
    input  wire [3:0]  regAddr,
    input  wire [7:0]  regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [7:0]  regRdData,
    // Receiver conditions and source requests
    input  wire        rxFifoFull,
    input  wire        rxError,
    input  wire        rxDataReady,
    input  wire        txIrqReq,
    input  wire        turnIrqReq,
    input  wire        timerIrqReq,
    input  wire        nmiReq,
    // Bidirectional pin
    input  wire        bidirIrqPinIn,
    output reg         bidirIrqPinOut,
    output reg         bidirIrqPinOe,
    // Core stack and flag controls
    input  wire        retPush,
    input  wire        retPop,
    input  wire        flagLoad,
    input  wire        flagCarryLoad,
    input  wire        aluCarry,
    input  wire        aluNegative,
    input  wire        aluOverflow,
    input  wire        aluZero,
    // Interrupt outputs
    output reg         irqReq,
    output reg  [15:0] irqVector,
    output reg         irqPending
);

    reg [1:0]  rxSel_q;
    reg [4:0]  irqMask_q;
    reg        globalEn_q;
    reg        bidirDir_q;
    reg [7:0]  vecBase_q;
    reg [3:0]  retPtr_q;
    reg [3:0]  opPtr_q;
    reg [7:0]  opStack [0:DEPTH-1];
    reg [3:0]  flags_q;
    reg        pinMeta_q;
    reg        pinSync_q;
    reg [5:0]  status_q;
    reg [5:0]  enable_q;
    reg        rxCause;
    reg [4:0]  active;
    reg [5:0]  code;
    reg [5:0]  events;
    reg [7:0]  rdMux;

    // Register write and read decodes; one strobe per register keeps the
    // update processes short and makes the write-only and read-only
    // offsets easy to see
    wire       wrControl = regWr & (regAddr == `OFS_IRQ_CONTROL);
    wire       wrBase    = regWr & (regAddr == `OFS_VECTOR_BASE);
    wire       wrPtrs    = regWr & (regAddr == `OFS_STACK_PTRS);
    wire       wrStack   = regWr & (regAddr == `OFS_DATA_STACK);
    wire       wrFlags   = regWr & (regAddr == `OFS_COND_CODES);
    wire       wrAux     = regWr & (regAddr == `OFS_AUX_CONTROL);
    wire       wrClear   = regWr & (regAddr == `OFS_IRQ_CLEAR);
    wire       wrEnable  = regWr & (regAddr == `OFS_IRQ_ENABLE);
    wire       rdStack   = regRd & (regAddr == `OFS_DATA_STACK);

    // Receiver cause by select field; 00 is fifo full or error, 01 and 10
    // bring in the data-ready condition, 11 is fifo full alone
    always @*
    begin
        case (rxSel_q)
            2'h0:    rxCause = rxFifoFull | rxError;
            2'h1:    rxCause = rxDataReady | rxError;
            2'h2:    rxCause = rxDataReady;
            default: rxCause = rxFifoFull;
        endcase
    end

    // Per-source gating; bit 3 only masks the pin while it is an input,
    // since in output mode the same bit is the level driven onto the pin
    always @*
    begin
        active[0] = rxCause & ~irqMask_q[0];
        active[1] = txIrqReq & ~irqMask_q[1];
        active[2] = turnIrqReq & ~irqMask_q[2];
        active[3] = ~bidirDir_q & pinSync_q & ~irqMask_q[`BIT_BIDIR_MASK];
        active[4] = timerIrqReq & ~irqMask_q[4];
        if (!globalEn_q)
            active = 5'h00;
    end

    // Fixed priority encoder; NMI bypasses enable and mask. With nothing
    // pending the timer code is shown, so the vector is never undefined
    // and the core must qualify it with the request output
    always @*
    begin
        if (nmiReq)
            code = `VEC_NMI;
        else if (active[0])
            code = `VEC_RX;
        else if (active[1])
            code = `VEC_TX;
        else if (active[2])
            code = `VEC_TURN;
        else if (active[3])
            code = `VEC_BIDIR;
        else
            code = `VEC_TIMER;
    end

    // Sticky event bits: index 0..4 sources, 5 NMI; sources are taken after
    // gating so a masked source never shows in the status register
    always @*
    begin
        events = {nmiReq, active};
    end

    // Read multiplexer; the stack port reads the current top entry.
    // Write-only and unmapped offsets read as zero, and the read strobe
    // of the stack port pops, so software must not poll that offset
    always @*
    begin
        case (regAddr)
            `OFS_IRQ_CONTROL: rdMux = {rxSel_q, 1'b0, irqMask_q};
            `OFS_VECTOR_BASE: rdMux = vecBase_q;
            `OFS_STACK_PTRS:  rdMux = {retPtr_q, opPtr_q};
            `OFS_DATA_STACK:  rdMux = opStack[opPtr_q - 4'h1];
            `OFS_COND_CODES:  rdMux = {3'h0, pinSync_q, flags_q};
            `OFS_AUX_CONTROL: rdMux = {6'h0, bidirDir_q, globalEn_q};
            `OFS_IRQ_STATUS:  rdMux = {2'h0, status_q};
            `OFS_IRQ_ENABLE:  rdMux = {2'h0, enable_q};
            `OFS_VECTOR_OUT:  rdMux = {2'h0, code};
            default:          rdMux = 8'h00;
        endcase
    end

    // Stack memory has no reset so its contents start undefined; that lets
    // it map onto plain storage cells
    always @(posedge clk)
    begin
        if (wrStack)
            opStack[opPtr_q] <= regWrData;
    end

    // Two-flop synchroniser for the pin; only the second stage is read,
    // which costs two cycles of latency on the pin request but keeps a
    // metastable first stage away from the gating logic
    always @(posedge clk)
    begin
        if (rst)
        begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= bidirIrqPinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // Interrupt control: receiver select and the five source masks; all
    // sources start masked so nothing but NMI fires before software is ready
    always @(posedge clk)
    begin
        if (rst)
        begin
            rxSel_q   <= `RST_RX_SEL;
            irqMask_q <= `RST_MASK;
        end
        else if (wrControl)
        begin
            rxSel_q   <= regWrData[7:6];
            irqMask_q <= regWrData[4:0];
        end
    end

    // Auxiliary control: global enable and pin direction; the pin starts
    // as an input so the block never fights an external driver at reset
    always @(posedge clk)
    begin
        if (rst)
        begin
            globalEn_q <= 1'b0;
            bidirDir_q <= 1'b0;
        end
        else if (wrAux)
        begin
            globalEn_q <= regWrData[`BIT_GLOBAL_EN];
            bidirDir_q <= regWrData[`BIT_BIDIR_DIR];
        end
    end

    // Vector base byte
    always @(posedge clk)
    begin
        if (rst)
            vecBase_q <= `RST_VECTOR_BASE;
        else if (wrBase)
            vecBase_q <= regWrData;
    end

    // Interrupt enable register, same layout as the status register
    always @(posedge clk)
    begin
        if (rst)
            enable_q <= 6'h00;
        else if (wrEnable)
            enable_q <= regWrData[5:0];
    end

    // Return stack pointer; a software write beats a simultaneous push or
    // pop, and push beats pop; the pointer wraps silently, so the core must
    // not nest deeper than the stack
    always @(posedge clk)
    begin
        if (rst)
            retPtr_q <= `RST_STACK_PTR;
        else if (wrPtrs)
            retPtr_q <= regWrData[7:4];
        else if (retPush)
            retPtr_q <= retPtr_q + 4'h1;
        else if (retPop)
            retPtr_q <= retPtr_q - 4'h1;
    end

    // Operand stack pointer; a port write pushes and a port read pops
    always @(posedge clk)
    begin
        if (rst)
            opPtr_q <= `RST_STACK_PTR;
        else if (wrPtrs)
            opPtr_q <= regWrData[3:0];
        else if (wrStack)
            opPtr_q <= opPtr_q + 4'h1;
        else if (rdStack)
            opPtr_q <= opPtr_q - 4'h1;
    end

    // Condition flags; a core update wins over a software write of the
    // flag byte, since the instruction result is the newer value
    always @(posedge clk)
    begin
        if (rst)
            flags_q <= 4'h0;
        else if (flagLoad)
        begin
            flags_q[`BIT_FLAG_N] <= aluNegative;
            flags_q[`BIT_FLAG_Z] <= aluZero;
            flags_q[`BIT_FLAG_V] <= aluOverflow;
            if (flagCarryLoad)
                flags_q[`BIT_FLAG_C] <= aluCarry;
        end
        else if (wrFlags)
            flags_q <= regWrData[3:0];
    end

    // Sticky status: a new event wins over a clear in the same cycle, so a
    // request arriving just as software clears its bit is never lost
    always @(posedge clk)
    begin
        if (rst)
            status_q <= 6'h00;
        else if (wrClear)
            status_q <= (status_q & ~regWrData[5:0]) | events;
        else
            status_q <= status_q | events;
    end

    // Read data stands for one cycle after the strobe and is zero
    // otherwise, so a bus that ORs several slaves needs no gating
    always @(posedge clk)
    begin
        if (rst)
            regRdData <= 8'h00;
        else if (regRd)
            regRdData <= rdMux;
        else
            regRdData <= 8'h00;
    end

    // Pin outputs; the enable is active low, so after reset the block
    // leaves the pin alone until software turns it into an output
    always @(posedge clk)
    begin
        if (rst)
        begin
            bidirIrqPinOut <= 1'b0;
            bidirIrqPinOe  <= 1'b1;
        end
        else
        begin
            bidirIrqPinOut <= irqMask_q[`BIT_BIDIR_MASK];
            bidirIrqPinOe  <= ~bidirDir_q;
        end
    end

    // Request, vector and level interrupt; request and vector lag their cause by
    // one cycle, the level interrupt a source event by two via the sticky status, which the core must allow for when it samples the vector
    always @(posedge clk)
    begin
        if (rst)
        begin
            irqReq     <= 1'b0;
            irqVector  <= 16'h0000;
            irqPending <= 1'b0;
        end
        else
        begin
            irqReq     <= nmiReq | (|active);
            irqVector  <= {vecBase_q, 2'b00, code};
            irqPending <= |(status_q & enable_q);
        end
    end

endmodule // interrupt_stack_status

//--- hdl/irq_stack_consts.vh
/*
 * Register offsets, field positions, reset values and vector codes for the
 * interrupt, stack and condition-code block. Definitions only; included by
 * interrupt_stack_status.v.
 */
`ifndef IRQ_STACK_CONSTS_VH
`define IRQ_STACK_CONSTS_VH
// Register offsets on the plain register port
`define OFS_IRQ_CONTROL   4'h0
`define OFS_VECTOR_BASE   4'h1
`define OFS_STACK_PTRS    4'h2
`define OFS_DATA_STACK    4'h3
`define OFS_COND_CODES    4'h4
`define OFS_AUX_CONTROL   4'h5
`define OFS_IRQ_STATUS    4'h6
`define OFS_IRQ_CLEAR     4'h7
`define OFS_IRQ_ENABLE    4'h8
`define OFS_VECTOR_OUT    4'h9
// Field positions
`define BIT_GLOBAL_EN     0
`define BIT_BIDIR_DIR     1
`define BIT_BIDIR_MASK    3
`define BIT_FLAG_Z        0
`define BIT_FLAG_C        1
`define BIT_FLAG_V        2
`define BIT_FLAG_N        3
`define BIT_BIDIR_PIN     4
// Reset values
`define RST_MASK          5'h1f
`define RST_RX_SEL        2'h3
`define RST_VECTOR_BASE   8'h00
`define RST_STACK_PTR     4'h0
// Six-bit vector codes
`define VEC_NMI           6'h1c
`define VEC_RX            6'h04
`define VEC_TX            6'h08
`define VEC_TURN          6'h0c
`define VEC_BIDIR         6'h10
`define VEC_TIMER         6'h14
// Stack depth
`define STACK_DEPTH       16
`endif

//--- testbench/interrupt_stack_status_asserts.sv
/* Port checker for interrupt_stack_status.
   Assumes one clock and a synchronous active-high reset; bound below. */
`timescale 1ns/10ps
module interrupt_stack_status_asserts (
    input logic        clk,
    input logic        rst,
    input logic [3:0]  regAddr,
    input logic [7:0]  regWrData,
    input logic        regWr,
    input logic        regRd,
    input logic [7:0]  regRdData,
    input logic        nmiReq,
    input logic        bidirIrqPinOut,
    input logic        bidirIrqPinOe,
    input logic        irqReq,
    input logic [15:0] irqVector,
    input logic        irqPending
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Read data stands only in the slot after a read strobe
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    // Non-maskable request wins past every gate and priority
    AST_NMI: assert property (nmiReq |=> irqReq)
        else $error("nmi not requested");
    AST_NMI_VEC: assert property (nmiReq |=> irqVector[5:0] == 6'h1c)
        else $error("nmi code wrong");
    AST_VEC_GAP: assert property (irqVector[7:6] == 2'b00 && irqVector[1:0] == 2'b00)
        else $error("vector zero bits set");
    // Register writes reach the outputs two edges later
    AST_BASE: assert property (regWr && regAddr == 4'h1 |-> ##2 irqVector[15:8] == $past(regWrData, 2))
        else $error("vector high byte wrong");
    AST_PIN_LVL: assert property (regWr && regAddr == 4'h0 |-> ##2 bidirIrqPinOut == $past(regWrData[3], 2))
        else $error("pin level not mask bit");
    AST_PIN_DIR: assert property (regWr && regAddr == 4'h5 |-> ##2 bidirIrqPinOe == !$past(regWrData[1], 2))
        else $error("pin direction wrong");
    // Reset must quiet the outputs, so it cannot be its own disable
    AST_RST: assert property (disable iff (1'b0) rst |=> bidirIrqPinOe && !irqReq && !irqPending)
        else $error("outputs active after reset");
endmodule // interrupt_stack_status_asserts

bind interrupt_stack_status interrupt_stack_status_asserts interrupt_stack_status_asserts_i (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .nmiReq(nmiReq), .bidirIrqPinOut(bidirIrqPinOut), .bidirIrqPinOe(bidirIrqPinOe),
    .irqReq(irqReq), .irqVector(irqVector), .irqPending(irqPending));

//--- testbench/test_interrupt_stack_status.sv
/* Self-checking bench for interrupt_stack_status.
   Assumes the designer's register map and one 100 MHz clock. */
`timescale 1ns/10ps
module test_interrupt_stack_status;
    logic        clk, rst, regWr, regRd, extPin;
    logic [3:0]  regAddr, alu;
    logic [7:0]  regWrData;
    logic [6:0]  src;
    logic [1:0]  ret, fl;
    wire  [7:0]  regRdData;
    wire  [15:0] irqVector;
    wire         pinOut, pinOe, irqReq, irqPending, pinIn;
    int          errors, checked, cyc;
    // Pin level: the block drives it while its enable is low
    assign pinIn = pinOe ? extPin : pinOut;
    interrupt_stack_status interrupt_stack_status_i (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .rxFifoFull(src[0]), .rxError(src[1]), .rxDataReady(src[2]),
        .txIrqReq(src[3]), .turnIrqReq(src[4]), .timerIrqReq(src[5]), .nmiReq(src[6]),
        .bidirIrqPinIn(pinIn), .bidirIrqPinOut(pinOut), .bidirIrqPinOe(pinOe), .retPush(ret[0]),
        .retPop(ret[1]), .flagLoad(fl[0]), .flagCarryLoad(fl[1]), .aluCarry(alu[1]), .aluNegative(alu[3]),
        .aluOverflow(alu[2]), .aluZero(alu[0]), .irqReq(irqReq), .irqVector(irqVector), .irqPending(irqPending));
    // Shared compare, bus cycles and settling
    task chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task w;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regWrData <= d; regWr <= 1;
        @(posedge clk);
        regWr <= 0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a; regRd <= 1;
        @(posedge clk);
        regRd <= 0;
        #1 chk(regRdData, e);
    endtask
    task req(input logic [6:0] s, input logic [15:0] v);
        @(posedge clk) src <= s;
        w;
        chk(irqVector, v);
    endtask
    task t_reset;
        w;
        chk(irqVector, 16'h0014);
        rd(0, 8'hdf);
        rd(1, 8'h00);
        rd(2, 8'h00);
        rd(4, 8'h00);
        rd(5, 8'h00);
    endtask
    task t_gate;
        wr(0, 8'hc0);
        req(7'h08, 16'h0014);
        chk(irqReq, 0);
        wr(5, 8'h01);
        w;
        chk(irqReq, 1);
        wr(0, 8'hc2);
        w;
        chk(irqReq, 0);
    endtask
    task t_prio;
        wr(0, 8'hc0);
        req(7'h30, 16'h000c);
        req(7'h38, 16'h0008);
        req(7'h39, 16'h0004);
        wr(1, 8'ha5);
        req(7'h79, 16'ha51c);
        req(7'h20, 16'ha514);
        wr(0, 8'h00);
        req(7'h02, 16'ha504);
        req(7'h01, 16'ha504);
        wr(0, 8'h40);
        req(7'h04, 16'ha504);
        wr(0, 8'h80);
        req(7'h01, 16'ha514);
        chk(irqReq, 0);
    endtask
    task t_bidir;
        @(posedge clk) src <= 0;
        wr(0, 8'h00);
        @(posedge clk) extPin <= 1;
        w;
        chk(irqVector, 16'ha510);
        rd(4, 8'h10);
        wr(0, 8'h08);
        w;
        chk(irqReq, 0);
        wr(5, 8'h03);
        @(posedge clk) extPin <= 0;
        w;
        chk({pinOe, pinOut, irqReq}, 3'b010);
        rd(4, 8'h10);
        wr(0, 8'h00);
        w;
        rd(4, 8'h00);
    endtask
    task t_stack;
        wr(2, 8'h0e);
        wr(3, 8'h11);
        wr(3, 8'h22);
        rd(2, 8'h00);
        rd(3, 8'h22);
        rd(3, 8'h11);
        @(posedge clk) ret <= 2'b01;
        @(posedge clk) ret <= 2'b00;
        rd(2, 8'h1e);
        wr(2, 8'h50);
        @(posedge clk) ret <= 2'b10;
        @(posedge clk) ret <= 2'b00;
        rd(2, 8'h40);
    endtask
    task t_flags;
        @(posedge clk) {alu, fl} <= 6'h3f;
        @(posedge clk) fl <= 0;
        rd(4, 8'h0f);
        @(posedge clk) {alu, fl} <= 6'h01;
        @(posedge clk) fl <= 0;
        rd(4, 8'h02);
    endtask
    task t_intr;
        @(posedge clk) src <= 0;
        wr(7, 8'hff);
        wr(8, 8'h02);
        req(7'h08, 16'ha508);
        chk(irqPending, 1);
        req(7'h00, 16'ha514);
        chk(irqPending, 1);
        rd(6, 8'h02);
        wr(7, 8'h02);
        w;
        chk(irqPending, 0);
        wr(8, 8'h00);
        req(7'h08, 16'ha508);
        chk(irqPending, 0);
        rd(4'hf, 8'h00);
    endtask
    // Mid-run reset after the return pointer and registers hold other values
    task t_rerst;
        @(posedge clk) rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        t_reset;
    endtask
    task conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Free-running clock
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Main sequence
    initial
    begin
        {regWr, regRd, extPin, regAddr, alu, regWrData, src, ret, fl} = '0;
        rst = 1;
        repeat (6) @(posedge clk);
        rst <= 0;
        t_reset;
        t_gate;
        t_prio;
        t_bidir;
        t_stack;
        t_flags;
        t_intr;
        t_rerst;
        conclude;
    end
    // Cut a hang short; the run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            conclude;
        end
    end
endmodule // test_interrupt_stack_status
